// File: bench/cpu_core_model.sv
`timescale 1ns/10ps
module cpu_core_model #(
  parameter logic [31:0] START_PC = 32'h00001000
) (
  // Clock and reset
  input logic sys_clk_i,
  input logic rst_n_i,
  // Return branch and its target
  input logic branch_ret_i,
  input logic [31:0] mrp_i,
  // Address of the packet in E1
  output logic [31:0] e1_pc_o
);
  // The packet address moves only on a return branch.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      e1_pc_o <= START_PC;
    end else if (branch_ret_i) begin
      e1_pc_o <= mrp_i;
    end
  end
endmodule : cpu_core_model

// File: bench/irq_status_checker_props.sv
`timescale 1ns/10ps
module irq_status_checker (
  // Clock and reset
  input logic sys_clk_i,
  input logic rst_n_i,
  // Block inputs
  input logic [15:0] maskable_sources_i,
  input logic maskable_take_i,
  input logic nonmaskable_take_i,
  input logic [31:0] return_addr_i,
  input logic [15:0] source_enable_i,
  input logic cr_wr_en_i,
  input logic [3:0] cr_wr_sel_i,
  input logic [31:0] cr_wr_data_i,
  // Block outputs
  input logic [15:0] pending_flags_o,
  input logic [31:0] maskable_return_pointer_o,
  input logic [31:0] nonmaskable_return_pointer_o,
  input logic [31:0] service_fetch_addr_o,
  input logic [4:0] highest_pending_number_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rsv; pending_flags_o[3:2] == 2'h0 && !pending_flags_o[0]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag bit set");
  property p_evt; (pending_flags_o & $past(maskable_sources_i) & 16'hFFF0) == ($past(maskable_sources_i) & 16'hFFF0);
  endproperty
  a_evt: assert property (p_evt) else $error("event did not set flag");
  property p_set; cr_wr_en_i && cr_wr_sel_i == 4'h1 |-> ##2
    (pending_flags_o & $past(cr_wr_data_i[15:0], 2) & 16'hFFF0) == ($past(cr_wr_data_i[15:0], 2) & 16'hFFF0);
  endproperty
  a_set: assert property (p_set) else $error("forced flag missing");
  property p_clr; cr_wr_en_i && cr_wr_sel_i == 4'h2 ##1 maskable_sources_i == 16'h0 |-> ##1
    (pending_flags_o & $past(cr_wr_data_i[15:0], 2) & 16'hFFF0) == 16'h0; endproperty
  a_clr: assert property (p_clr) else $error("cleared flag remains");
  property p_mrp; maskable_take_i |=> maskable_return_pointer_o == $past(return_addr_i); endproperty
  a_mrp: assert property (p_mrp) else $error("maskable pointer not loaded");
  property p_nrp; nonmaskable_take_i |=> nonmaskable_return_pointer_o == $past(return_addr_i); endproperty
  a_nrp: assert property (p_nrp) else $error("nonmaskable pointer not loaded");
  property p_stp; service_fetch_addr_o[9:0] == {highest_pending_number_o, 5'h00}; endproperty
  a_stp: assert property (p_stp) else $error("table pointer low bits wrong");
  property p_hpe; (pending_flags_o & source_enable_i & 16'hFFF2) == 16'h0 |=> highest_pending_number_o == 5'h00;
  endproperty
  a_hpe: assert property (p_hpe) else $error("highest number not zero");
endmodule : irq_status_checker
bind cpu_interrupt_status_pointers irq_status_checker irq_status_checker_i (.*);

// File: bench/testbench.sv
`timescale 1ns/10ps
module testbench;
  typedef struct packed {logic [3:0] sel; logic [31:0] wd; logic [31:0] rexp;} row_t;
  logic sys_clk_i;
  logic rst_n_i = 1'b0;
  logic [15:0] src = 16'h0;
  logic nmi = 1'b0;
  logic mtake = 1'b0;
  logic ntake = 1'b0;
  logic [15:0] en = 16'h0;
  logic wr_en = 1'b0;
  logic [3:0] wr_sel = 4'h0;
  logic [31:0] wr_data = 32'h0;
  logic rd_en = 1'b0;
  logic [3:0] rd_sel = 4'h0;
  logic ret = 1'b0;
  logic [15:0] ack = 16'h0;
  logic [31:0] pc, rd_data, mrp, nonmaskable_return_pointer, stp;
  logic [15:0] flags;
  logic [4:0] hpn;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  row_t rows [8] = '{'{4'h1, 32'hFFFFFFFF, 32'h0}, '{4'h0, 32'hFFFFFFFF, 32'h0000FFF0},
    '{4'h2, 32'hFFFFFFFF, 32'h0}, '{4'h0, 32'h0, 32'h0}, '{4'h3, 32'h12345678, 32'h12345678},
    '{4'h4, 32'h89ABCDEF, 32'h89ABCDEF}, '{4'h5, 32'hFFFFFFFF, 32'hFFFFFC00}, '{4'h7, 32'hFFFFFFFF, 32'h0}};
  cpu_interrupt_status_pointers cpu_interrupt_status_pointers_i (.sys_clk_i, .rst_n_i,
    .maskable_sources_i(src), .nonmaskable_event_i(nmi), .flag_ack_i(ack), .maskable_take_i(mtake),
    .nonmaskable_take_i(ntake), .return_addr_i(pc), .source_enable_i(en), .e1_pc_i(pc), .cr_wr_en_i(wr_en),
    .cr_wr_sel_i(wr_sel), .cr_wr_data_i(wr_data), .cr_rd_en_i(rd_en), .cr_rd_sel_i(rd_sel),
    .cr_rd_data_o(rd_data), .pending_flags_o(flags), .maskable_return_pointer_o(mrp),
    .nonmaskable_return_pointer_o(nonmaskable_return_pointer), .service_fetch_addr_o(stp), .highest_pending_number_o(hpn));
  cpu_core_model cpu_core_model_i (.sys_clk_i, .rst_n_i, .branch_ret_i(ret), .mrp_i(mrp), .e1_pc_o(pc));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [3:0] ws, input logic [31:0] wd, input logic r, input logic [3:0] rs);
    @(posedge sys_clk_i);
    wr_en <= w;
    wr_sel <= ws;
    wr_data <= wd;
    rd_en <= r;
    rd_sel <= rs;
  endtask : acc
  task automatic rd_chk(input logic [3:0] rs, input logic [31:0] exp, input string name);
    acc(0, 4'h0, 32'h0, 1, rs);
    acc(0, 4'h0, 32'h0, 0, 4'h0);
    #1;
    chk(name, exp, rd_data);
  endtask : rd_chk
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk_i);
    chk("reset table pointer", 32'h0, stp);
    rst_n_i <= 1'b1;
    foreach (rows[i]) begin
      acc(1, rows[i].sel, rows[i].wd, 0, 4'h0);
      acc(0, 4'h0, 32'h0, 0, 4'h0);
      rd_chk(rows[i].sel, rows[i].rexp, "table read");
    end
    acc(1, 4'h1, 32'h00000020, 0, 4'h0);
    acc(0, 4'h0, 32'h0, 1, 4'h0);
    acc(0, 4'h0, 32'h0, 0, 4'h0);
    #1;
    chk("early read", 32'h0, rd_data);
    rd_chk(4'h0, 32'h00000020, "late read");
    acc(1, 4'h2, 32'h00000220, 0, 4'h0);
    acc(0, 4'h0, 32'h0, 0, 4'h0);
    src <= 16'h0200;
    nmi <= 1'b1;
    @(posedge sys_clk_i);
    src <= 16'h0;
    nmi <= 1'b0;
    #1;
    chk("event over clear", 32'h00000202, flags);
    @(posedge sys_clk_i);
    en <= 16'h0200;
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk("highest masked", 32'h9, hpn);
    rd_chk(4'h5, 32'hFFFFFD20, "table read nine");
    @(posedge sys_clk_i);
    en <= 16'h0202;
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk("table pointer one", 32'hFFFFFC20, stp);
    @(posedge sys_clk_i);
    mtake <= 1'b1;
    ntake <= 1'b1;
    @(posedge sys_clk_i);
    mtake <= 1'b0;
    ntake <= 1'b0;
    #1;
    chk("maskable take", 32'h00001000, mrp);
    chk("nonmaskable take", 32'h00001000, nonmaskable_return_pointer);
    acc(1, 4'h3, 32'h00004020, 0, 4'h0);
    acc(0, 4'h0, 32'h0, 0, 4'h0);
    ret <= 1'b1;
    @(posedge sys_clk_i);
    ret <= 1'b0;
    rd_chk(4'h6, 32'h00004020, "e1 pc");
    acc(1, 4'h3, 32'h77770000, 0, 4'h0);
    mtake <= 1'b1;
    acc(0, 4'h0, 32'h0, 0, 4'h0);
    mtake <= 1'b0;
    #1;
    chk("take over write", 32'h00004020, mrp);
    @(posedge sys_clk_i);
    ack <= 16'h0202;
    src <= 16'h0200;
    @(posedge sys_clk_i);
    ack <= 16'h0;
    src <= 16'h0;
    #1;
    chk("event over acknowledge", 32'h00000200, flags);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk("reset restores table base", 32'h0, stp);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd_chk(4'h5, 32'h0, "table read after reset");
    rd_chk(4'h0, 32'h0, "flags after reset");
    end_sim();
  end
endmodule : testbench

// File: logic/cpu_interrupt_status_pointers.sv
// Summary of operation
// - Maskable events 4..15 set their pending flag.
// - Nonmaskable event sets its own flag bit 1.
// - Pending reserved bits read zero, writes ignored.
// - Force-set write of one sets maskable flag.
// - Force-set cannot touch nonmaskable or reset.
// - Forced flag readable two cycles after write.
// - Same-bit force-set beats force-clear.
// - Force-set reserved bits read zero, discarded.
// - Maskable take loads first skipped packet address.
// - Maskable pointer writable, later takes overwrite it.
// - Nonmaskable take loads nonmaskable return pointer.
// - Pointers and E1 counter carry no meaning.
// - Table base resets to default, then writable.
// - Relocated reset entry never fetched by interrupts.
// - Field reports lowest-numbered pending enabled flag number.
// - Maskable sources ignore global and nonmaskable enable.
// - Low five table pointer bits always read zero.
// - E1 counter shows current E1 packet, read-only.
// - Force-clear write of one clears maskable flag.
// - Hardware event beats software clear same cycle.
// - Only enabled sources count as enabled.
`timescale 1ns/10ps
`include "cpu_irq_params.svh"

module cpu_interrupt_status_pointers #(
  parameter logic [`TABLE_BASE_W-1:0] TABLE_BASE_DEFAULT = `TABLE_BASE_RESET
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Interrupt events, one-cycle pulses
  input wire logic [`FLAG_W-1:0] maskable_sources_i,
  input wire logic nonmaskable_event_i,
  // Flag acknowledge from the pipeline when an interrupt is taken
  input wire logic [`FLAG_W-1:0] flag_ack_i,
  // Interrupt acceptance with its return address
  input wire logic maskable_take_i,
  input wire logic nonmaskable_take_i,
  input wire logic [`PTR_W-1:0] return_addr_i,
  // Contents of the source enable register
  input wire logic [`FLAG_W-1:0] source_enable_i,
  // Address of the fetch packet now in E1
  input wire logic [`PTR_W-1:0] e1_pc_i,
  // Control-register move write port
  input wire logic cr_wr_en_i,
  input wire logic [`CR_SEL_W-1:0] cr_wr_sel_i,
  input wire logic [`PTR_W-1:0] cr_wr_data_i,
  // Control-register move read port
  input wire logic cr_rd_en_i,
  input wire logic [`CR_SEL_W-1:0] cr_rd_sel_i,
  output logic [`PTR_W-1:0] cr_rd_data_o,
  // Status towards the pipeline
  output logic [`FLAG_W-1:0] pending_flags_o,
  output logic [`PTR_W-1:0] maskable_return_pointer_o,
  output logic [`PTR_W-1:0] nonmaskable_return_pointer_o,
  output logic [`PTR_W-1:0] service_fetch_addr_o,
  output logic [`HPE_W-1:0] highest_pending_number_o
);

  irq_status_pkg::irq_state_t state_reg;
  irq_status_pkg::irq_state_t state_next;

  // Write strobes and writable bits of the move port.
  logic wr_force_set;
  logic wr_clear;
  logic wr_mrp;
  logic wr_nrp;
  logic wr_stp;
  logic [`FLAG_W-1:0] set_bits;
  logic [`FLAG_W-1:0] clr_bits;

  // Flag update paths.
  logic [`FLAG_W-1:0] hw_set;
  logic [`FLAG_W-1:0] flag_keep;
  logic [`FLAG_W-1:0] flag_upd;

  // Highest pending number.
  logic [`FLAG_W-1:0] enabled_req;
  logic hpe_found;
  logic [`HPE_W-1:0] hpe_now;
  logic [`HPE_W-1:0] hpe_sel;

  // Pointer updates.
  logic [`PTR_W-1:0] mrp_upd;
  logic [`PTR_W-1:0] nrp_upd;

  // Read path.
  logic [`PTR_W-1:0] stp_now;
  logic [`PTR_W-1:0] pending_word;
  logic [`PTR_W-1:0] rd_word;

  // Write decode of the control-register move port.
  always_comb begin
    wr_force_set = 1'b0;
    wr_clear = 1'b0;
    wr_mrp = 1'b0;
    wr_nrp = 1'b0;
    wr_stp = 1'b0;
    if (cr_wr_en_i) begin
      case (cr_wr_sel_i)
        `CR_SEL_FORCE_SET: begin
          wr_force_set = 1'b1;
        end
        `CR_SEL_CLEAR: begin
          wr_clear = 1'b1;
        end
        `CR_SEL_MRP: begin
          wr_mrp = 1'b1;
        end
        `CR_SEL_NRP: begin
          wr_nrp = 1'b1;
        end
        `CR_SEL_STP: begin
          wr_stp = 1'b1;
        end
        default: begin
          // Writes to the pending flags, the E1 counter and unused codes are dropped.
          wr_force_set = 1'b0;
        end
      endcase
    end
  end

  // Hardware events mapped onto flag positions.
  always_comb begin
    hw_set = maskable_sources_i & `MASKABLE_MASK;
    hw_set[`NMI_BIT] = nonmaskable_event_i;
  end

  // Writable bits of the force-set and force-clear registers.
  always_comb begin
    set_bits = `FLAGS_NONE;
    clr_bits = `FLAGS_NONE;
    if (wr_force_set) begin
      set_bits = cr_wr_data_i[`FLAG_W-1:0] & `MASKABLE_MASK;
    end
    if (wr_clear) begin
      clr_bits = cr_wr_data_i[`FLAG_W-1:0] & `MASKABLE_MASK;
    end
  end

  // Bits that exist in the pending-flag register.
  assign flag_keep = `MASKABLE_MASK | `NMI_MASK;

  // Per-flag update: a clear acts first, a software set or a hardware event then overrides it.
  for (genvar b = 0; b < `FLAG_W; b++) begin : g_flag
    logic cleared;
    logic raised;
    logic upd;
    always_comb begin
      cleared = state_reg.staged_clr[b] | flag_ack_i[b];
      raised = state_reg.staged_set[b] | hw_set[b];
      upd = state_reg.flags[b];
      if (cleared) begin
        upd = 1'b0;
      end
      if (raised) begin
        upd = 1'b1;
      end
    end
    assign flag_upd[b] = upd & flag_keep[b];
  end

  // Candidate sources for the highest pending number.
  always_comb begin
    enabled_req = state_reg.flags & source_enable_i & `MASKABLE_MASK;
    enabled_req[`NMI_BIT] = state_reg.flags[`NMI_BIT] & source_enable_i[`NMI_BIT];
  end

  irq_priority_encoder #(
    .W(`FLAG_W),
    .IDX_W(`HPE_W)
  ) u_priority (
    .req_i(enabled_req),
    .found_o(hpe_found),
    .index_o(hpe_now)
  );

  // Highest pending number, zero when nothing is pending and enabled.
  always_comb begin
    hpe_sel = `HPE_NONE;
    if (hpe_found) begin
      hpe_sel = hpe_now;
    end
  end

  // Service fetch packet address as seen by a read.
  always_comb begin
    stp_now = {state_reg.table_base, hpe_sel, `ALIGN_ZERO};
    pending_word = `WORD_ZERO;
    pending_word[`FLAG_W-1:0] = state_reg.flags & (`MASKABLE_MASK | `NMI_MASK);
  end

  // Return pointers: a take overrides a software write in the same cycle.
  always_comb begin
    mrp_upd = state_reg.mrp;
    nrp_upd = state_reg.nonmaskable_return_pointer;
    if (wr_mrp) begin
      mrp_upd = cr_wr_data_i;
    end
    if (maskable_take_i) begin
      mrp_upd = return_addr_i;
    end
    if (wr_nrp) begin
      nrp_upd = cr_wr_data_i;
    end
    if (nonmaskable_take_i) begin
      nrp_upd = return_addr_i;
    end
  end

  // Read multiplexer; write-only and unmapped codes read zero.
  always_comb begin
    rd_word = `WORD_ZERO;
    case (cr_rd_sel_i)
      `CR_SEL_PENDING: begin
        rd_word = pending_word;
      end
      `CR_SEL_FORCE_SET: begin
        rd_word = `WORD_ZERO;
      end
      `CR_SEL_CLEAR: begin
        rd_word = `WORD_ZERO;
      end
      `CR_SEL_MRP: begin
        rd_word = state_reg.mrp;
      end
      `CR_SEL_NRP: begin
        rd_word = state_reg.nonmaskable_return_pointer;
      end
      `CR_SEL_STP: begin
        rd_word = stp_now;
      end
      `CR_SEL_EXECUTE_PHASE_PC: begin
        rd_word = state_reg.execute_phase_pc;
      end
      default: begin
        rd_word = `WORD_ZERO;
      end
    endcase
  end

  // Next-state logic.
  always_comb begin
    state_next = state_reg;

    // Software writes are staged one cycle so they land with one delay slot.
    state_next.staged_set = set_bits;
    state_next.staged_clr = clr_bits;

    // Flags after clears, software sets and hardware events.
    state_next.flags = flag_upd;

    // Return pointers, loaded by a take or a software write.
    state_next.mrp = mrp_upd;
    state_next.nonmaskable_return_pointer = nrp_upd;

    // Table base relocation; only reset restores the default.
    if (wr_stp) begin
      state_next.table_base = cr_wr_data_i[`PTR_W-1:`TABLE_BASE_LSB];
    end

    // E1 program counter follows the pipeline every cycle.
    state_next.execute_phase_pc = e1_pc_i;

    // Highest pending number kept for the pipeline side.
    state_next.hpe = hpe_sel;

    // Read data is registered and holds until the next read.
    if (cr_rd_en_i) begin
      state_next.rd_data = rd_word;
    end
  end

  // State register. Pointers are cleared only to keep simulation clean; their value is meaningless.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg.flags <= `FLAGS_RESET;
      state_reg.staged_set <= `FLAGS_NONE;
      state_reg.staged_clr <= `FLAGS_NONE;
      state_reg.mrp <= `PTR_RESET;
      state_reg.nonmaskable_return_pointer <= `PTR_RESET;
      state_reg.execute_phase_pc <= `PTR_RESET;
      state_reg.table_base <= TABLE_BASE_DEFAULT;
      state_reg.hpe <= `HPE_NONE;
      state_reg.rd_data <= `WORD_ZERO;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register.
  assign cr_rd_data_o = state_reg.rd_data;
  assign pending_flags_o = state_reg.flags;
  assign maskable_return_pointer_o = state_reg.mrp;
  assign nonmaskable_return_pointer_o = state_reg.nonmaskable_return_pointer;
  assign service_fetch_addr_o = {state_reg.table_base, state_reg.hpe, `ALIGN_ZERO};
  assign highest_pending_number_o = state_reg.hpe;

endmodule : cpu_interrupt_status_pointers

// File: logic/cpu_irq_params.svh
`ifndef CPU_IRQ_PARAMS_SVH
`define CPU_IRQ_PARAMS_SVH

// Control-register select codes on the move port.
`define CR_SEL_W 4
`define CR_SEL_PENDING 4'h0
`define CR_SEL_FORCE_SET 4'h1
`define CR_SEL_CLEAR 4'h2
`define CR_SEL_MRP 4'h3
`define CR_SEL_NRP 4'h4
`define CR_SEL_STP 4'h5
`define CR_SEL_EXECUTE_PHASE_PC 4'h6

// Flag layout.
`define FLAG_W 16
`define NMI_BIT 1
`define MASKABLE_MASK 16'hFFF0
`define NMI_MASK 16'h0002
`define FLAGS_RESET 16'h0000
`define FLAGS_NONE 16'h0000

// Service-table pointer layout.
`define TABLE_BASE_LSB 10
`define TABLE_BASE_W 22
`define HPE_W 5
`define ALIGN_ZERO 5'h00
`define HPE_NONE 5'h00
`define TABLE_BASE_RESET 22'h000000

// Pointer widths and reset values.
`define PTR_W 32
`define PTR_RESET 32'h00000000
`define WORD_ZERO 32'h00000000

`endif

// File: logic/irq_priority_encoder.sv
`timescale 1ns/10ps

module irq_priority_encoder #(
  parameter int W = 16,
  parameter int IDX_W = 5
) (
  // Requests, lowest index has highest priority
  input wire logic [W-1:0] req_i,
  // Result
  output logic found_o,
  output logic [IDX_W-1:0] index_o
);

  // Scans from the top so that the lowest requesting index is left last.
  always_comb begin
    found_o = 1'b0;
    index_o = '0;
    for (int i = W - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        found_o = 1'b1;
        index_o = IDX_W'(i);
      end
    end
  end

endmodule : irq_priority_encoder

// File: logic/irq_status_pkg.sv
`include "cpu_irq_params.svh"

package irq_status_pkg;

  // Complete state of the interrupt status block.
  typedef struct packed {
    logic [`FLAG_W-1:0] flags;
    logic [`FLAG_W-1:0] staged_set;
    logic [`FLAG_W-1:0] staged_clr;
    logic [`PTR_W-1:0] mrp;
    logic [`PTR_W-1:0] nonmaskable_return_pointer;
    logic [`PTR_W-1:0] execute_phase_pc;
    logic [`TABLE_BASE_W-1:0] table_base;
    logic [`HPE_W-1:0] hpe;
    logic [`PTR_W-1:0] rd_data;
  } irq_state_t;

endpackage : irq_status_pkg
